/* src/adc_cmd_receiver.sv */
`timescale 1ns/1ps
module adc_cmd_receiver (
    // Link clock and reset request
    input  wire logic       sclk_in,
    input  wire logic       link_rst_n_in,
    // Serial pins
    input  wire logic       cs_n_in,
    input  wire logic       din_in,
    // Command toward the converter domain
    output logic [7:0]      cmd_code_out,
    output logic            cmd_toggle_out
);

    adc_serial_pkg::link_t st;
    adc_serial_pkg::link_t next_st;
    logic [7:0]            byte_in;

    always_comb begin
        next_st = st;
        byte_in = {st.shreg[6:0], din_in};
        next_st.rst_s1 = link_rst_n_in;
        next_st.rst_s2 = st.rst_s1;
        if (!st.rst_s2) begin
            next_st.bit_cnt = 3'h0;
            next_st.phase   = adc_serial_pkg::P_CMD;
            next_st.code    = adc_serial_pkg::CMD_NOP;
            next_st.tog     = 1'b0;
        end else if (cs_n_in) begin
            next_st.bit_cnt = 3'h0;
            next_st.phase   = adc_serial_pkg::P_CMD;
        end else begin
            // Framing by edge count alone, so a tied-low select still works
            next_st.shreg   = byte_in; // R12
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7) begin
                case (st.phase)
                    adc_serial_pkg::P_CMD: begin
                        if (byte_in[7:4] == adc_serial_pkg::CMD_REGISTER_READ ||
                            byte_in[7:4] == adc_serial_pkg::CMD_REGISTER_WRITE) begin
                            next_st.phase = adc_serial_pkg::P_ARG;
                        end else begin
                            // Code is stable well before the toggle is seen across
                            next_st.code = byte_in; // R5
                            next_st.tog  = ~st.tog;
                        end
                        if (byte_in[7:4] == adc_serial_pkg::CMD_REGISTER_READ ||
                            byte_in[7:4] == adc_serial_pkg::CMD_REGISTER_WRITE) begin
                            next_st.code = byte_in;
                        end
                    end
                    adc_serial_pkg::P_ARG: begin
                        if (st.code[7:4] == adc_serial_pkg::CMD_REGISTER_WRITE) begin
                            next_st.phase = adc_serial_pkg::P_DAT;
                        end else begin
                            next_st.phase = adc_serial_pkg::P_CMD;
                            next_st.tog   = ~st.tog;
                        end
                    end
                    adc_serial_pkg::P_DAT: begin
                        next_st.phase = adc_serial_pkg::P_CMD;
                        next_st.tog   = ~st.tog;
                    end
                    default: begin
                        next_st.phase = adc_serial_pkg::P_CMD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sclk_in) begin
        st <= next_st;
    end

    assign cmd_code_out   = st.code;
    assign cmd_toggle_out = st.tog;

endmodule

/* src/adc_serial_pkg.sv */
package adc_serial_pkg;
// Contract
// R1: A low level on the power-down input stops all converter logic and releases every pin the converter drives.
// The code drives result ready high instead, and its synchronisers and idle count keep running.
// R2: The converter marks each fresh result by pulling its active-low result-ready output low.
// R3: For read, continuous read and register commands the host waits 50 oscillator periods before its first read edge.
// R4: The serial output is released 6 to 10 oscillator periods after the last serial edge, and at once on chip deselect.
// R5: After a register, sync, sleep, read or continuous command the host waits 4 oscillator periods before the next.
// R6: After a gain, offset or system calibration command the host waits 2 result-ready periods before the next.
// R7: After a full self-calibration the host waits 4 result-ready periods, and after a reset it waits 16.
// R8: In continuous read the host waits 10 oscillator periods after result-ready falls, otherwise it may clock at once.
// R9: While the output data register updates its contents are invalid for at least 4 oscillator periods.
// R10: An analog input change meant for the next conversion must land within 5000 oscillator periods.
// R11: Each analog input pin also serves as a digital input or output line of the same index.
// R12: The host may tie chip select low when alone on the bus, and framing then rests on edge counting alone.

    // The converter's oscillator clock is the block clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 10;

    localparam int RESULT_BITS = 24;
    localparam int DIO_BITS    = 8;
    localparam int CONV_W      = 24;

    localparam int DOUT_REL_MAX_OSC = 10;
    localparam int DOUT_REL_MAX_CYC = (DOUT_REL_MAX_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;
    // Sync, edge detect and the drive flop add up to three cycles on top of the idle count
    localparam logic [3:0] DOUT_IDLE_CYC = 4'(DOUT_REL_MAX_CYC - 5);

    localparam int DOR_UPDATE_OSC = 4;
    localparam logic [3:0] DOR_UPDATE_CYC = 4'((DOR_UPDATE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [4:0] CAL_SHORT_RESULT_READY_N = 5'h02;
    localparam logic [4:0] CAL_FULL_RESULT_READY_N  = 5'h04;
    localparam logic [4:0] RESET_RESULT_READY_N     = 5'h10;

    localparam logic [4:0] READ_BITS = 5'h18;
    localparam logic [4:0] REG_BITS  = 5'h08;

    // Command opcodes; zero is a no-op left behind by a link reset
    localparam logic [7:0] CMD_NOP             = 8'h00;
    localparam logic [7:0] CMD_READ_DATA       = 8'h01;
    localparam logic [7:0] CMD_CONTINUOUS_READ = 8'h03;
    localparam logic [7:0] CMD_STOP_CONTINUOUS = 8'h0F;
    localparam logic [3:0] CMD_REGISTER_READ   = 4'h1;
    localparam logic [3:0] CMD_REGISTER_WRITE  = 4'h5;
    localparam logic [7:0] CMD_FULL_SELF_CAL   = 8'hF0;
    localparam logic [7:0] CMD_OFFSET_SELF_CAL = 8'hF1;
    localparam logic [7:0] CMD_GAIN_SELF_CAL   = 8'hF2;
    localparam logic [7:0] CMD_SYS_OFFSET_CAL  = 8'hF3;
    localparam logic [7:0] CMD_SYS_GAIN_CAL    = 8'hF4;
    localparam logic [7:0] CMD_FILTER_SYNC     = 8'hFC;
    localparam logic [7:0] CMD_SLEEP           = 8'hFD;
    localparam logic [7:0] CMD_RESET           = 8'hFE;

    typedef enum logic [2:0] {
        P_CMD = 3'h1,
        P_ARG = 3'h2,
        P_DAT = 3'h4
    } phase_t;

    typedef enum logic [4:0] {
        S_RUN    = 5'h01,
        S_UPDATE = 5'h02,
        S_SLEEP  = 5'h04,
        S_DOWN   = 5'h08,
        S_IDLE   = 5'h10
    } conv_state_t;

    typedef struct packed {
        logic         rst_s1;
        logic         rst_s2;
        logic [2:0]   bit_cnt;
        logic [7:0]   shreg;
        phase_t       phase;
        logic [7:0]   code;
        logic         tog;
    } link_t;

    typedef struct packed {
        logic                   cs_s1;
        logic                   cs_s2;
        logic                   sck_s1;
        logic                   sck_s2;
        logic                   sck_s3;
        logic                   pd_s1;
        logic                   pd_s2;
        logic                   tog_s1;
        logic                   tog_s2;
        logic                   tog_seen;
        logic [DIO_BITS-1:0]    dio_s1;
        logic [DIO_BITS-1:0]    dio_s2;
        conv_state_t            state;
        logic [CONV_W-1:0]      conv_cnt;
        logic [3:0]             upd_cnt;
        logic [4:0]             wait_result_ready_n;
        logic                   ready_n;
        logic [RESULT_BITS-1:0] output_data_reg;
        logic                   cont;
        logic [RESULT_BITS-1:0] out_shift;
        logic [4:0]             out_left;
        logic [3:0]             idle_cnt;
        logic                   drive;
        logic [DIO_BITS-1:0]    dio_out;
        logic                   link_rst_n;
    } conv_t;

endpackage

/* src/adc_serial_port.sv */
`timescale 1ns/1ps
module adc_serial_port #(
    parameter logic [23:0] CONV_CYCLES = 24'h006000
) (
    // Clocks and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        sclk_in,
    // Serial pins
    input  wire logic        cs_n_in,
    input  wire logic        din_in,
    output logic             dout_out,
    output logic             dout_oe_n_out,
    output logic             result_ready_n_out,
    // Power down
    input  wire logic        power_down_n_in,
    // Converter core
    input  wire logic [23:0] conv_sample_in,
    // Shared analog and digital pins
    input  wire logic [7:0]  dio_pin_in,
    input  wire logic [7:0]  dio_drive_in,
    input  wire logic [7:0]  dio_level_in,
    output logic [7:0]       dio_pin_out,
    output logic [7:0]       dio_oe_n_out,
    output logic [7:0]       dio_read_out
);

    adc_serial_pkg::conv_t st;
    adc_serial_pkg::conv_t next_st;
    logic [7:0]            cmd_code;
    logic                  cmd_tog;
    logic                  sck_rise;
    logic                  sck_edge;
    logic                  cmd_event;

    adc_cmd_receiver u_rx (
        .sclk_in        (sclk_in),
        .link_rst_n_in  (st.link_rst_n),
        .cs_n_in        (cs_n_in),
        .din_in         (din_in),
        .cmd_code_out   (cmd_code),
        .cmd_toggle_out (cmd_tog)
    );

    assign sck_rise  = st.sck_s2 & ~st.sck_s3;
    assign sck_edge  = st.sck_s2 ^ st.sck_s3;
    assign cmd_event = st.tog_s2 != st.tog_seen;

    always_comb begin
        next_st          = st;
        next_st.cs_s1    = cs_n_in;
        next_st.cs_s2    = st.cs_s1;
        next_st.sck_s1   = sclk_in;
        next_st.sck_s2   = st.sck_s1;
        next_st.sck_s3   = st.sck_s2;
        next_st.pd_s1    = power_down_n_in;
        next_st.pd_s2    = st.pd_s1;
        next_st.tog_s1   = cmd_tog;
        next_st.tog_s2   = st.tog_s1;
        next_st.tog_seen = st.tog_s2;
        next_st.dio_s1   = dio_pin_in;
        next_st.dio_s2   = st.dio_s1; // R11
        next_st.dio_out  = dio_level_in; // R11
        next_st.link_rst_n = 1'b1;

        if (sck_edge) begin
            next_st.idle_cnt = 4'h0;
        end else if (st.idle_cnt < adc_serial_pkg::DOUT_IDLE_CYC) begin
            next_st.idle_cnt = st.idle_cnt + 4'h1;
        end

        // Host samples on the rising edge, so the bit advances just after it
        if (sck_rise && !st.cs_s2 && st.out_left != 5'h00) begin
            next_st.out_shift = {st.out_shift[22:0], 1'b0};
            next_st.out_left  = st.out_left - 5'h01;
        end

        case (st.state)
            adc_serial_pkg::S_RUN: begin
                if (st.conv_cnt == CONV_CYCLES - 24'h000001) begin
                    next_st.state    = adc_serial_pkg::S_UPDATE;
                    next_st.conv_cnt = '0;
                    next_st.upd_cnt  = 4'h0;
                    next_st.ready_n  = 1'b1; // R9
                end else begin
                    next_st.conv_cnt = st.conv_cnt + 24'h000001;
                end
            end
            adc_serial_pkg::S_UPDATE: begin
                if (st.upd_cnt == adc_serial_pkg::DOR_UPDATE_CYC - 4'h1) begin
                    next_st.state = adc_serial_pkg::S_RUN;
                    // Results during calibration or reset recovery are discarded
                    if (st.wait_result_ready_n != 5'h00) begin
                        next_st.wait_result_ready_n = st.wait_result_ready_n - 5'h01; // R6 R7
                    end else begin
                        next_st.output_data_reg     = conv_sample_in; // R9 R10
                        next_st.ready_n = 1'b0; // R2
                        if (st.cont) begin
                            // The 10-period wait covers this load and the sync delay
                            next_st.out_shift = conv_sample_in; // R8
                            next_st.out_left  = adc_serial_pkg::READ_BITS;
                        end
                    end
                end else begin
                    next_st.upd_cnt = st.upd_cnt + 4'h1;
                end
            end
            adc_serial_pkg::S_SLEEP: begin
                if (cmd_event && cmd_code != adc_serial_pkg::CMD_NOP) begin
                    next_st.state    = adc_serial_pkg::S_RUN;
                    next_st.conv_cnt = '0;
                end
            end
            adc_serial_pkg::S_DOWN: begin
                next_st.state    = adc_serial_pkg::S_RUN;
                next_st.conv_cnt = '0;
            end
            default: begin
                next_st.state = adc_serial_pkg::S_RUN;
            end
        endcase

        if (cmd_event && st.state != adc_serial_pkg::S_SLEEP) begin
            case (cmd_code)
                adc_serial_pkg::CMD_READ_DATA: begin
                    // Loaded within a few cycles; the host's 50-period wait hides it
                    next_st.out_shift = st.output_data_reg; // R3
                    next_st.out_left  = adc_serial_pkg::READ_BITS;
                    next_st.ready_n   = 1'b1;
                end
                adc_serial_pkg::CMD_CONTINUOUS_READ: begin
                    next_st.cont = 1'b1;
                end
                adc_serial_pkg::CMD_STOP_CONTINUOUS: begin
                    next_st.cont = 1'b0;
                end
                adc_serial_pkg::CMD_FILTER_SYNC: begin
                    next_st.state    = adc_serial_pkg::S_RUN;
                    next_st.conv_cnt = '0;
                end
                adc_serial_pkg::CMD_SLEEP: begin
                    next_st.state   = adc_serial_pkg::S_SLEEP;
                    next_st.ready_n = 1'b1;
                end
                adc_serial_pkg::CMD_RESET: begin
                    next_st.state     = adc_serial_pkg::S_RUN;
                    next_st.conv_cnt  = '0;
                    next_st.cont      = 1'b0;
                    next_st.ready_n   = 1'b1;
                    next_st.wait_result_ready_n = adc_serial_pkg::RESET_RESULT_READY_N; // R7
                end
                adc_serial_pkg::CMD_FULL_SELF_CAL: begin
                    next_st.wait_result_ready_n = adc_serial_pkg::CAL_FULL_RESULT_READY_N; // R7
                end
                adc_serial_pkg::CMD_OFFSET_SELF_CAL,
                adc_serial_pkg::CMD_GAIN_SELF_CAL,
                adc_serial_pkg::CMD_SYS_OFFSET_CAL,
                adc_serial_pkg::CMD_SYS_GAIN_CAL: begin
                    next_st.wait_result_ready_n = adc_serial_pkg::CAL_SHORT_RESULT_READY_N; // R6
                end
                default: begin
                    // Register file is not modelled: a register read returns zeros
                    if (cmd_code[7:4] == adc_serial_pkg::CMD_REGISTER_READ) begin
                        next_st.out_shift = '0; // R3
                        next_st.out_left  = adc_serial_pkg::REG_BITS;
                    end
                end
            endcase
        end

        next_st.drive = (next_st.out_left != 5'h00) ||
                        (next_st.idle_cnt < adc_serial_pkg::DOUT_IDLE_CYC); // R4

        // Power down clears state, counters, waits and drive; synchronisers, idle count and digital levels keep running
        if (!st.pd_s2) begin
            next_st.state      = adc_serial_pkg::S_DOWN; // R1
            next_st.conv_cnt   = '0;
            next_st.upd_cnt    = 4'h0;
            next_st.wait_result_ready_n  = 5'h00;
            next_st.ready_n    = 1'b1;
            next_st.cont       = 1'b0;
            next_st.out_left   = 5'h00;
            next_st.drive      = 1'b0;
            next_st.link_rst_n = 1'b0;
        end

        if (!resetn_in) begin
            next_st            = '0;
            next_st.cs_s1      = 1'b1;
            next_st.cs_s2      = 1'b1;
            next_st.state      = adc_serial_pkg::S_DOWN;
            next_st.ready_n    = 1'b1;
            next_st.idle_cnt   = adc_serial_pkg::DOUT_IDLE_CYC;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign dout_out           = st.out_shift[23];
    // Deselect must release at once, so the raw pin gates the enable
    assign dout_oe_n_out      = cs_n_in | ~st.drive; // R4
    assign result_ready_n_out = st.ready_n; // R2
    assign dio_pin_out        = st.dio_out;
    assign dio_read_out       = st.dio_s2;

    genvar i;
    generate
        for (i = 0; i < adc_serial_pkg::DIO_BITS; i++) begin : g_dio
            assign dio_oe_n_out[i] = ~(dio_drive_in[i] & st.pd_s2); // R11 R1
        end
    endgenerate

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_pd_quiet: assert property (!st.pd_s2 |=> st.state == adc_serial_pkg::S_DOWN && result_ready_n_out && dout_oe_n_out) // R1
        else $error("power down left outputs active");

    chk_ready_fall: assert property ($fell(result_ready_n_out) |-> $past(st.state) == adc_serial_pkg::S_UPDATE && st.output_data_reg == $past(conv_sample_in)) // R2
        else $error("result ready fell without a fresh result");

    chk_update_hold: assert property ($rose(st.state == adc_serial_pkg::S_UPDATE) |-> result_ready_n_out [*4]) // R9
        else $error("result ready low during data update");

    chk_release_late: assert property (disable iff (!resetn_in || !st.pd_s2)
        (sck_edge && st.out_left == 5'h00) ##1 (!sck_edge && st.out_left == 5'h00) [*6] |-> dout_oe_n_out) // R4
        else $error("serial output still driven after idle time");

    chk_release_early: assert property (disable iff (!resetn_in || !st.pd_s2)
        sck_edge |=> st.drive [*5]) // R4
        else $error("serial output released too soon");

    chk_cs_release: assert property (cs_n_in && st.drive |-> dout_oe_n_out) // R4
        else $error("serial output driven while deselected");

    chk_dio_read: assert property (resetn_in [*3] |-> dio_read_out == $past(dio_pin_in, 2)) // R11
        else $error("digital read does not follow the pin");

endmodule

/* test/host_model.sv */
`timescale 1ns/1ps
module host_model (
    // Oscillator clock for spacing counts
    input  wire logic clk_in,
    // Serial pins
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      din_out,
    input  wire logic dout_in,
    input  wire logic dout_oe_n_in
);
    // Link clock idles low and runs inside frames and in flush with select high
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out  = 1'b0;
    end

    task automatic osc_wait(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Select stays low after a byte, as when the converter is alone on the bus
    task automatic send_byte(input logic [7:0] b);
        cs_n_out = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            din_out = b[i];
            #32 sclk_out = 1'b1;
            #32 sclk_out = 1'b0;
        end
        // Released data line must not keep showing the last bit
        din_out = ~b[0];
    endtask

    // Sample at the rising edge; a released output reads as unknown
    task automatic read_bits(input int n, output logic [23:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            #32 sclk_out = 1'b1;
            v = {v[22:0], (dout_oe_n_in === 1'b0) ? dout_in : 1'bx};
            #32 sclk_out = 1'b0;
        end
    endtask

    // Full command with read-back, keeping the host spacing
    task automatic read_cmd(input logic [7:0] cmd, input int n, output logic [23:0] v);
        send_byte(cmd);
        osc_wait(50);
        read_bits(n, v);
    endtask

    task automatic gap();
        osc_wait(4);
    endtask

    task automatic deselect();
        cs_n_out = 1'b1;
    endtask

    // Pulses with select high clear the receiver's framing and carry its reset across
    task automatic flush();
        cs_n_out = 1'b1;
        repeat (4) begin
            #32 sclk_out = 1'b1;
            #32 sclk_out = 1'b0;
        end
    endtask
endmodule

/* test/test_adc_serial_command_timing.sv */
`timescale 1ns/1ps
module test_adc_serial_command_timing;
    // Short conversion so calibration waits stay cheap
    localparam logic [23:0] CONV   = 24'h000100;
    localparam int          PERIOD = 260;
    localparam int          LIMIT  = 30000;

    logic        clk_in;
    logic        resetn_in;
    logic        power_down_n;
    logic [23:0] conv_sample;
    logic [7:0]  dio_pin;
    logic [7:0]  dio_drive;
    logic [7:0]  dio_level;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe_n;
    logic        result_ready_n;
    logic [7:0]  dio_pin_o;
    logic [7:0]  dio_oe_n;
    logic [7:0]  dio_read;
    logic [23:0] v;
    int          mismatches;
    int          samples_checked;
    int          cycles;

    adc_serial_port #(.CONV_CYCLES(CONV)) dut_u (
        .clk_in             (clk_in),
        .resetn_in          (resetn_in),
        .sclk_in            (sclk),
        .cs_n_in            (cs_n),
        .din_in             (din),
        .dout_out           (dout),
        .dout_oe_n_out      (dout_oe_n),
        .result_ready_n_out (result_ready_n),
        .power_down_n_in    (power_down_n),
        .conv_sample_in     (conv_sample),
        .dio_pin_in         (dio_pin),
        .dio_drive_in       (dio_drive),
        .dio_level_in       (dio_level),
        .dio_pin_out        (dio_pin_o),
        .dio_oe_n_out       (dio_oe_n),
        .dio_read_out       (dio_read)
    );

    host_model host_u (
        .clk_in       (clk_in),
        .sclk_out     (sclk),
        .cs_n_out     (cs_n),
        .din_out      (din),
        .dout_in      (dout),
        .dout_oe_n_in (dout_oe_n)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask

    // Next fresh falling edge of result ready, bounded
    task automatic wait_fall(input int bound, output int n);
        n = 0;
        while (result_ready_n !== 1'b1 && n < bound) begin
            tick();
            n++;
        end
        while (result_ready_n !== 1'b0 && n < bound) begin
            tick();
            n++;
        end
    endtask

    task automatic t_ready();
        int n;
        int hi;
        wait_fall(2 * PERIOD, n);
        check(24'(n < 2 * PERIOD), 24'h000001);
        while (result_ready_n === 1'b0 && hi < PERIOD) begin
            tick();
            hi++;
        end
        hi = 0;
        while (result_ready_n === 1'b1 && hi < 100) begin
            tick();
            hi++;
        end
        check(24'(hi), 24'h000004);
        $display("t_ready done");
    endtask

    task automatic t_read();
        int n;
        wait_fall(2 * PERIOD, n);
        host_u.send_byte(adc_serial_pkg::CMD_READ_DATA);
        host_u.osc_wait(50);
        check(24'(result_ready_n), 24'h000001);
        host_u.read_bits(24, v);
        check(v, 24'hA5C3E1);
        check(24'(dout_oe_n), 24'h000000);
        repeat (10) @(posedge clk_in);
        #1;
        check(24'(dout_oe_n), 24'h000001);
        host_u.gap();
        $display("t_read done");
    endtask

    task automatic t_cs_release();
        // A whole byte keeps the receiver's edge count on a byte boundary
        host_u.read_cmd(adc_serial_pkg::CMD_READ_DATA, 8, v);
        check(v, 24'h0000A5);
        check(24'(dout_oe_n), 24'h000000);
        host_u.deselect();
        #1;
        check(24'(dout_oe_n), 24'h000001);
        host_u.gap();
        $display("t_cs_release done");
    endtask

    task automatic t_cont();
        int n;
        // A new input level well inside the allowed change window
        @(posedge clk_in) conv_sample <= 24'h3C5A96;
        host_u.send_byte(adc_serial_pkg::CMD_CONTINUOUS_READ);
        host_u.gap();
        wait_fall(2 * PERIOD, n);
        wait_fall(2 * PERIOD, n);
        host_u.osc_wait(10);
        host_u.read_bits(24, v);
        check(v, 24'h3C5A96);
        host_u.send_byte(adc_serial_pkg::CMD_STOP_CONTINUOUS);
        host_u.gap();
        $display("t_cont done");
    endtask

    task automatic t_cal();
        logic [7:0] cmds [6];
        int         cnt [6];
        int         n;
        cmds = '{adc_serial_pkg::CMD_OFFSET_SELF_CAL, adc_serial_pkg::CMD_GAIN_SELF_CAL,
                 adc_serial_pkg::CMD_SYS_OFFSET_CAL, adc_serial_pkg::CMD_SYS_GAIN_CAL,
                 adc_serial_pkg::CMD_FULL_SELF_CAL, adc_serial_pkg::CMD_RESET};
        cnt  = '{2, 2, 2, 2, 4, 16};
        for (int i = 0; i < 6; i++) begin
            wait_fall(2 * PERIOD, n);
            host_u.send_byte(cmds[i]);
            host_u.gap();
            // Measuring the gap also keeps the host idle for the whole settling wait
            wait_fall((cnt[i] + 2) * PERIOD, n);
            check(24'(n > cnt[i] * PERIOD - 60 && n <= (cnt[i] + 1) * PERIOD + 10), 24'h000001);
        end
        $display("t_cal done");
    endtask

    task automatic t_dio();
        @(posedge clk_in);
        dio_drive <= 8'h5A;
        dio_level <= 8'h3C;
        dio_pin   <= 8'h96;
        repeat (4) tick();
        check(24'(dio_oe_n), 24'h0000A5);
        check(24'(dio_pin_o), 24'h00003C);
        check(24'(dio_read), 24'h000096);
        $display("t_dio done");
    endtask

    task automatic t_sleep();
        int n;
        int lows;
        host_u.send_byte(adc_serial_pkg::CMD_SLEEP);
        host_u.gap();
        lows = 0;
        repeat (PERIOD + 20) begin
            tick();
            lows += (result_ready_n !== 1'b1);
        end
        check(24'(lows), 24'h000000);
        // Any non-zero byte wakes the converter without being executed
        host_u.send_byte(adc_serial_pkg::CMD_READ_DATA);
        host_u.gap();
        wait_fall(2 * PERIOD, n);
        check(24'(n < 2 * PERIOD), 24'h000001);
        $display("t_sleep done");
    endtask

    task automatic t_pdown();
        int n;
        int lows;
        @(posedge clk_in) power_down_n <= 1'b0;
        repeat (3) tick();
        check(24'(result_ready_n), 24'h000001);
        check(24'(dout_oe_n), 24'h000001);
        check(24'(dio_oe_n), 24'h0000FF);
        lows = 0;
        repeat (2 * PERIOD) begin
            tick();
            lows += (result_ready_n !== 1'b1);
        end
        check(24'(lows), 24'h000000);
        @(posedge clk_in) power_down_n <= 1'b1;
        wait_fall(2 * PERIOD, n);
        check(24'(n < 2 * PERIOD), 24'h000001);
        $display("t_pdown done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        resetn_in       = 1'b0;
        power_down_n    = 1'b1;
        conv_sample     = 24'hA5C3E1;
        dio_pin         = 8'h00;
        dio_drive       = 8'h00;
        dio_level       = 8'h00;
        mismatches      = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (10) @(posedge clk_in);
        #1;
        check(24'(result_ready_n), 24'h000001);
        check(24'(dout_oe_n), 24'h000001);
        @(posedge clk_in) resetn_in <= 1'b1;
        // The link side resets only while its clock runs, so pulse it under power down
        @(posedge clk_in) power_down_n <= 1'b0;
        repeat (4) tick();
        host_u.flush();
        repeat (8) tick();
        @(posedge clk_in) power_down_n <= 1'b1;
        repeat (4) tick();
        host_u.flush();
        repeat (8) tick();
        t_ready();
        t_read();
        t_cs_release();
        t_cont();
        t_cal();
        t_dio();
        t_sleep();
        t_pdown();
        wrap_up();
    end
endmodule
